// ===== serial_rx_pkg.sv
// Constants shared by the asynchronous serial receiver and its helpers.
// Assumes a single 250 MHz clock; the oversampling tick is made inside.
// Overview of operation
// - Full-duplex asynchronous NRZ link, one start, 8 or 9 data, stop bit.
// - Receiver runs only while the receiver enable bit 1 is set.
// - Input pin sampled at sixteen times the bit rate per bit.
// - Start seen on a low sample after three consecutive high samples.
// - Frame format field bits 2-3 selects data, parity and stop layout.
// - Bit 4 picks parity, zero odd one even; else ninth data bit.
// - Baud field bits 5-7 selects 600 to 38400 baud; code 111 unused.
// - Three samples per bit, majority taken; disagreement sets noise flag.
// - Noisy bit does not abort the frame; character still accepted.
// - Nine bit periods after start, ten for ninth bit, two stop, parity.
// - Framing error set on parity failure or missing stop bit.
// - Ten consecutive low bits signal a break and an interrupt request.
// - On stop, character with ninth bit loads holding buffer; full set.
// - Loading also captures that character's framing and noise flags.
// - Reading input register 18 returns character and clears full flag.
// - Character completing while full sets overrun, buffer left unchanged.
// - Bit recovery runs on the sample tick, buffer on the master clock.
package serial_rx_pkg;
  localparam logic [7:0] CONFIG_ADDR = 8'h14;
  localparam logic [7:0] DATA_ADDR = 8'h12;
  localparam logic [7:0] STATUS_ADDR = 8'h13;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam int RE_BIT = 1;
  localparam int FMT_LO = 2;
  localparam int NINTH_BIT = 4;
  localparam int BAUD_LO = 5;
  localparam logic [1:0] FMT_8N1 = 2'b00;
  localparam logic [1:0] FMT_8N2 = 2'b01;
  localparam logic [1:0] FMT_8P1 = 2'b10;
  localparam logic [1:0] FMT_9N1 = 2'b11;
  localparam logic [2:0] BAUD_UNUSED = 3'b111;
  // Status bit positions
  localparam int ST_FULL = 0;
  localparam int ST_OVR = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_FRAME = 3;
  localparam int ST_BREAK = 4;
  localparam int CLOCK_HZ = 250000000;
  localparam int BASE_BAUD = 600;
  localparam int OVERSAMPLE = 16;
  // Cycles per sample tick at 600 baud, halved per code step
  localparam int BASE_DIV = CLOCK_HZ / (BASE_BAUD * OVERSAMPLE);
  localparam logic [3:0] SAMPLE_LAST = 4'hf;
  localparam logic [3:0] VOTE_A = 4'h7;
  localparam logic [3:0] VOTE_B = 4'h8;
  localparam logic [3:0] VOTE_C = 4'h9;
  localparam logic [3:0] BITS_SHORT = 4'h9;
  localparam logic [3:0] BITS_LONG = 4'ha;
  localparam logic [3:0] BREAK_BITS = 4'ha;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W = 11;
endpackage : serial_rx_pkg

// ===== rx_sync.sv
// Two flip-flop synchroniser for one level.
// Assumes input is asynchronous to clock_i.
`timescale 1ns/1ps
module rx_sync
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  // Idle line level is high
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b1;
      sync_o <= 1'b1;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : rx_sync

// ===== rx_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides.
// Assumes one clock for both sides.
`timescale 1ns/1ps
module rx_fifo
#(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;
  // Handshake terms
  assign in_ready_o = (count_q != (AW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q];
  // Storage
  always_ff @(posedge clock_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end
  // Pointers and fill count
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : rx_fifo

// ===== async_serial_receiver.sv
// Receive half of the serial interface: bit recovery and holding buffer.
// Assumes core register access by address with write and read strobes.
`timescale 1ns/1ps
module async_serial_receiver
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic serial_input_pin_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  output logic [7:0] serial_line_config_o,
  output logic parity_or_ninth_bit_o,
  output logic break_irq_o
);
  import serial_rx_pkg::*;

  // Bit recovery states: waiting, start bit, data and stop bits
  typedef enum logic [1:0] {IDLE, START, DATA} rx_state_type;

  logic [7:0] cfg_q;
  logic rx_s;
  logic [19:0] div_q;
  logic [19:0] div_limit;
  logic tick_q;
  rx_state_type state_q;
  logic [2:0] hist_q;
  logic [3:0] phase_q;
  logic [3:0] bit_q;
  logic [3:0] bits_needed;
  logic [9:0] shift_q;
  logic [2:0] votes_q;
  logic noise_acc_q;
  logic [3:0] low_run_q;
  logic done_q;
  logic [WORD_W-1:0] done_word_q;
  logic fifo_ready;
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_word;
  logic pop_q;
  logic [8:0] hold_q;
  logic full_q;
  logic ovr_q;
  logic noise_q;
  logic frame_q;
  logic brk_q;
  logic receiver_enable;
  logic [1:0] fmt;
  logic [2:0] baud_rate_select;
  logic majority;
  logic disagree;
  logic last_bit;
  logic parity_bad;
  logic stop_bad;
  logic read_data;
  logic read_status;

  // ---------------------------------------------------------------
  // Configuration register
  // ---------------------------------------------------------------
  assign receiver_enable = cfg_q[RE_BIT];
  assign fmt = cfg_q[FMT_LO +: 2];
  assign baud_rate_select = cfg_q[BAUD_LO +: 3];
  assign read_data = reg_read_i && (reg_addr_i == DATA_ADDR);
  assign read_status = reg_read_i && (reg_addr_i == STATUS_ADDR);

  // Core writes of the line configuration
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      cfg_q <= CONFIG_RESET;
    else if (reg_write_i && reg_addr_i == CONFIG_ADDR)
      cfg_q <= reg_wdata_i;
  end

  // Configuration mirrored for the rest of the chip
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      serial_line_config_o <= CONFIG_RESET;
      parity_or_ninth_bit_o <= 1'b0;
    end
    else
    begin
      serial_line_config_o <= cfg_q;
      parity_or_ninth_bit_o <= cfg_q[NINTH_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Oversampling tick
  // ---------------------------------------------------------------
  // Pin passes two flip-flops before any logic reads it
  rx_sync u_sync
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(serial_input_pin_i),
    .sync_o(rx_s)
  );

  // Divider halves per baud code step
  // Rates are nominal; the clock does not divide exactly
  assign div_limit = 20'((BASE_DIV >> baud_rate_select) - 1);

  // Sample tick at sixteen times the bit rate
  // Disabled or unused code stops the tick and restarts the divider
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else if (!receiver_enable || baud_rate_select == BAUD_UNUSED)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else if (div_q >= div_limit)
    begin
      div_q <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Bit recovery
  // ---------------------------------------------------------------
  // Frame length after start bit
  assign bits_needed = (fmt == FMT_8N1) ? BITS_SHORT : BITS_LONG;
  assign majority = (votes_q[0] & votes_q[1]) | (votes_q[0] & votes_q[2])
    | (votes_q[1] & votes_q[2]);
  assign disagree = !(votes_q[0] == votes_q[1] && votes_q[1] == votes_q[2]);
  assign last_bit = (bit_q == bits_needed);
  // Parity over eight data bits and parity bit, bit 4 picks even
  assign parity_bad = (fmt == FMT_8P1) &&
    ((^shift_q[9:1]) != !cfg_q[NINTH_BIT]);
  // Stop bit must be high, and the first of two stop bits too
  assign stop_bad = !majority ||
    ((fmt == FMT_8N2) && !shift_q[9]);

  // Sample state machine, stepped by the tick
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= IDLE;
      hist_q <= '0;
      phase_q <= '0;
      bit_q <= '0;
      shift_q <= '0;
      votes_q <= '0;
      noise_acc_q <= 1'b0;
      done_q <= 1'b0;
      done_word_q <= '0;
    end
    else
    begin
      done_q <= 1'b0;
      if (!receiver_enable)
      begin
        state_q <= IDLE;
        hist_q <= '0;
      end
      else if (tick_q)
      begin
        case (state_q)
          IDLE:
          begin
            // Shift in the line, look for three highs then a low
            hist_q <= {hist_q[1:0], rx_s};
            if (hist_q == 3'b111 && !rx_s)
            begin
              state_q <= START;
              phase_q <= 4'h1;
              noise_acc_q <= 1'b0;
            end
          end
          START:
          begin
            // Let the rest of the start bit pass
            phase_q <= phase_q + 1'b1;
            if (phase_q == SAMPLE_LAST)
            begin
              state_q <= DATA;
              bit_q <= 4'h1;
              phase_q <= '0;
            end
          end
          DATA:
          begin
            // Three votes near the middle of the bit
            phase_q <= phase_q + 1'b1;
            if (phase_q == VOTE_A)
              votes_q[0] <= rx_s;
            if (phase_q == VOTE_B)
              votes_q[1] <= rx_s;
            if (phase_q == VOTE_C)
              votes_q[2] <= rx_s;
            // Bit done: keep the vote and count the bit
            if (phase_q == SAMPLE_LAST)
            begin
              noise_acc_q <= noise_acc_q | disagree;
              bit_q <= bit_q + 1'b1;
              shift_q <= {majority, shift_q[9:1]};
              // Last bit: hand over the word and its flags
              if (last_bit)
              begin
                state_q <= IDLE;
                hist_q <= '0;
                done_q <= 1'b1;
                done_word_q <= {noise_acc_q | disagree,
                  parity_bad | stop_bad,
                  (fmt == FMT_9N1) ? shift_q[9] : cfg_q[NINTH_BIT],
                  (fmt == FMT_8N1) ? shift_q[9:2] : shift_q[8:1]};
              end
            end
          end
          default: state_q <= IDLE;
        endcase
      end
    end
  end

  // Run of low bits for break detection
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      low_run_q <= '0;
      brk_q <= 1'b0;
    end
    else
    begin
      // Status read clears the flag; a break seen now still wins
      if (read_status)
        brk_q <= 1'b0;
      if (tick_q && state_q == DATA && phase_q == SAMPLE_LAST)
      begin
        if (majority)
          low_run_q <= '0;
        else if (low_run_q != BREAK_BITS - 4'h2)
          low_run_q <= low_run_q + 1'b1;
        else
          brk_q <= 1'b1;
      end
      else if (state_q == IDLE && rx_s)
        low_run_q <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Character FIFO and holding buffer
  // ---------------------------------------------------------------
  rx_fifo
  #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  )
  u_fifo
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(done_q),
    .in_ready_o(fifo_ready),
    .in_data_i(done_word_q),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop_q),
    .out_data_o(fifo_word)
  );

  // Drain pulse, one word per cycle at most
  // The FIFO drains at once, so each word meets the buffer as it lands
  assign pop_q = fifo_valid;

  // Holding buffer and its flags, event wins over clear
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hold_q <= '0;
      full_q <= 1'b0;
      ovr_q <= 1'b0;
      noise_q <= 1'b0;
      frame_q <= 1'b0;
    end
    else
    begin
      // Data read empties the buffer; a word arriving now refills it
      if (read_data)
      begin
        full_q <= 1'b0;
        ovr_q <= 1'b0;
      end
      // Full and not read now: keep the old word, flag the loss
      if (pop_q && full_q && !read_data)
        ovr_q <= 1'b1;
      else if (pop_q || (done_q && !fifo_ready))
      begin
        hold_q <= fifo_word[8:0];
        frame_q <= fifo_word[9];
        noise_q <= fifo_word[10];
        full_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= '0;
      break_irq_o <= 1'b0;
    end
    else
    begin
      // Interrupt request mirrors the break flag
      break_irq_o <= brk_q;
      // Read data follows the address one cycle later
      case (reg_addr_i)
        DATA_ADDR: reg_rdata_o <= hold_q[7:0];
        STATUS_ADDR: reg_rdata_o <= {3'h0, brk_q, frame_q, noise_q,
          ovr_q, full_q};
        CONFIG_ADDR: reg_rdata_o <= cfg_q;
        default: reg_rdata_o <= '0;
      endcase
    end
  end
endmodule : async_serial_receiver

// ===== async_serial_receiver_props.sv
// Checker for the serial receiver register ports.
// Assumes it is bound to every async_serial_receiver instance.
`timescale 1ns/1ps
module async_serial_receiver_checker
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic serial_input_pin_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] serial_line_config_o,
  input wire logic parity_or_ninth_bit_o,
  input wire logic break_irq_o
);
  import serial_rx_pkg::*;
  // --------------------------------
  // Register port properties
  // --------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_cfg_write;
    reg_write_i && reg_addr_i == CONFIG_ADDR ##1 !reg_write_i
      |=> serial_line_config_o == $past(reg_wdata_i, 2);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config copy wrong");
  property p_ninth;
    reg_write_i && reg_addr_i == CONFIG_ADDR ##1 !reg_write_i
      |=> parity_or_ninth_bit_o == $past(reg_wdata_i[NINTH_BIT], 2);
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("ninth bit output wrong");
  property p_unmapped;
    reg_addr_i > CONFIG_ADDR |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_clear_full;
    reg_read_i && reg_addr_i == DATA_ADDR ##2 reg_addr_i == STATUS_ADDR
      |=> !reg_rdata_o[ST_FULL];
  endproperty
  a_clear_full: assert property (p_clear_full)
    else $error("full flag kept after data read");
  property p_clear_break;
    reg_read_i && reg_addr_i == STATUS_ADDR |-> ##2 !break_irq_o;
  endproperty
  a_clear_break: assert property (p_clear_break)
    else $error("break request kept after status read");
  property p_reset;
    $fell(rst_i) |-> reg_rdata_o == 8'h00 && !break_irq_o
      && serial_line_config_o == CONFIG_RESET;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not clear after reset");
  property p_cfg_stable;
    reg_addr_i == CONFIG_ADDR && $stable(reg_addr_i) && !reg_write_i
      && !$past(reg_write_i) && !$past(reg_write_i, 2) |=> $stable(reg_rdata_o);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable)
    else $error("config read changed without write");
  property p_status_hi;
    reg_addr_i == STATUS_ADDR |=> reg_rdata_o[7:5] == 3'h0;
  endproperty
  a_status_hi: assert property (p_status_hi)
    else $error("status upper bits set");
endmodule : async_serial_receiver_checker

bind async_serial_receiver async_serial_receiver_checker u_checker
(
  .clock_i(clock_i), .rst_i(rst_i), .serial_input_pin_i(serial_input_pin_i),
  .reg_addr_i(reg_addr_i), .reg_write_i(reg_write_i),
  .reg_wdata_i(reg_wdata_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .serial_line_config_o(serial_line_config_o),
  .parity_or_ninth_bit_o(parity_or_ninth_bit_o), .break_irq_o(break_irq_o)
);

// ===== rx_remote_tx.sv
// Remote transmitter model driving the serial line.
// Assumes the caller builds the frame bits, start bit first.
`timescale 1ns/1ps
module rx_remote_tx
#(
  parameter int TICK = 406
)
(
  input wire logic clock_i,
  output logic line_o
);
  // Line idles high between frames
  initial line_o = 1'b1;
  // Hold one level for a number of clock cycles
  task automatic hold(input logic v, input int cyc);
    line_o = v;
    repeat (cyc) @(posedge clock_i);
    #1;
  endtask : hold
  // Send n bits; bit index g carries a one-tick inverted glitch
  task automatic send(input logic [11:0] f, input int n, input int g);
    @(posedge clock_i);
    #1;
    for (int i = 0; i < n; i++)
      if (i == g)
      begin
        hold(f[i], 8 * TICK);
        hold(!f[i], TICK);
        hold(f[i], 7 * TICK);
      end
      else
        hold(f[i], 16 * TICK);
    line_o = 1'b1;
  endtask : send
endmodule : rx_remote_tx

// ===== async_serial_receiver_tb_top.sv
// Self-checking bench for the serial receiver.
// Assumes the remote transmitter model and the bound checker.
`timescale 1ns/1ps
module async_serial_receiver_tb_top;
  import serial_rx_pkg::*;
  localparam int TICK = BASE_DIV >> 6;
  logic clock_i, rst_i, line, reg_write_i, reg_read_i, ninth, brk;
  logic [7:0] addr, wdata, rdata, cfg, v, got;
  logic e_full, e_ovr, e_noise, e_frame;
  logic [7:0] held[$];
  logic [31:0] lfsr = 32'hb0b9;
  int err_count, n_tests, cycles;
  async_serial_receiver u_async_serial_receiver
  (
    .clock_i(clock_i), .rst_i(rst_i), .serial_input_pin_i(line),
    .reg_addr_i(addr), .reg_write_i(reg_write_i), .reg_wdata_i(wdata),
    .reg_read_i(reg_read_i), .reg_rdata_o(rdata),
    .serial_line_config_o(cfg), .parity_or_ninth_bit_o(ninth),
    .break_irq_o(brk)
  );
  rx_remote_tx #(.TICK(TICK)) u_rx_remote_tx
  (
    .clock_i(clock_i),
    .line_o(line)
  );
  // --------------------------------
  // Tasks
  // --------------------------------
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1 addr = a;
    wdata = d;
    reg_write_i = 1'b1;
    @(posedge clock_i);
    #1 reg_write_i = 1'b0;
  endtask : wr
  // Read strobe one cycle, data registered at the next edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    #1 addr = a;
    reg_read_i = 1'b1;
    @(posedge clock_i);
    #1 reg_read_i = 1'b0;
    d = rdata;
    if (a == DATA_ADDR && held.size() > 0)
      void'(held.pop_front());
    if (a == DATA_ADDR)
      {e_full, e_ovr} = 2'b00;
  endtask : rd
  function automatic logic [7:0] st_exp();
    return {4'h0, e_frame, e_noise, e_ovr, e_full};
  endfunction : st_exp
  // Send one character and update the model
  task automatic rx(input logic par, input logic bad, input int g);
    logic [7:0] d;
    logic [11:0] f;
    lfsr = step(lfsr);
    d = lfsr[7:0];
    f = par ? {1'b1, ^d ^ bad, d, 1'b0} : {2'b11, d, 1'b0};
    // Line idles long enough for three high samples first
    repeat (4 * TICK) @(posedge clock_i);
    u_rx_remote_tx.send(f, par ? 11 : 10, g);
    repeat (2 * TICK) @(posedge clock_i);
    if (e_full)
      e_ovr = 1'b1;
    else
    begin
      held.push_back(d);
      {e_full, e_noise, e_frame} = {1'b1, g >= 0, bad};
    end
  endtask : rx
  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // --------------------------------
  // Clock, timeout and sequence
  // --------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 300000)
    begin
      err_count++;
      $display("wrong value at %0t: timeout", $time);
      final_report;
    end
  end
  initial
  begin
    {rst_i, addr, wdata, reg_write_i, reg_read_i} = {1'b1, 18'h0};
    {e_full, e_ovr, e_noise, e_frame} = 4'h0;
    repeat (16) @(posedge clock_i);
    #1 rst_i = 1'b0;
    rd(STATUS_ADDR, v);
    check(v, 8'h00);
    rd(CONFIG_ADDR, v);
    check(v, CONFIG_RESET);
    rd(8'h20, v);
    check(v, 8'h00);
    $display("test reset done");
    wr(CONFIG_ADDR, 8'hc2);
    rd(CONFIG_ADDR, v);
    check(v, 8'hc2);
    check(cfg, 8'hc2);
    rx(1'b0, 1'b0, -1);
    rd(STATUS_ADDR, v);
    check(v, st_exp());
    check({7'h0, brk}, 8'h00);
    v = held[0];
    rd(DATA_ADDR, got);
    check(got, v);
    rd(STATUS_ADDR, v);
    check(v, st_exp());
    $display("test plain frame done");
    wr(CONFIG_ADDR, 8'hda);
    @(posedge clock_i);
    #1;
    check({7'h0, ninth}, 8'h01);
    rx(1'b1, 1'b1, 3);
    rd(STATUS_ADDR, v);
    check(v, st_exp());
    rx(1'b1, 1'b0, -1);
    rd(STATUS_ADDR, v);
    check(v, st_exp());
    v = held[0];
    rd(DATA_ADDR, got);
    check(got, v);
    rd(STATUS_ADDR, v);
    check(v, st_exp());
    $display("test parity and overrun done");
    final_report;
  end
endmodule : async_serial_receiver_tb_top
